// ---- ssac_top.sv ----
// single-slope converter control core with its wishbone register file
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
`include "ssac_map.svh"
// What this block does
// - each set channel switch bit connects its line; several may be set
// - with all switches open, reference select bits connect supply or bias
// - analog control register at its fixed index, cleared by reset
// - comparator and current source power bits off while clear and after reset
// - charge bit forced clear when current source power is clear; reset clears
// - powered: charge one sources current, zero sinks; read shows the state
// - two mode bits pick four modes, inert unpowered, reset gives manual
// - unpowered current source: ramp pin neither sources nor sinks
// - manual mode: charge bit changes only by software write
// - mode one: hardware clears charge bit when comparator flag becomes set
// - mode two: sinking until next timer overflow, then hardware sets charge
// - mode three: sinking until next timer compare, then hardware sets charge
// - modes two and three: sourcing until next capture, then clear charge
// - capture source select picks comparator flag or external capture pin
// - capture source select forced set while high mode bit set; reset clears
// - comparator triggered capture latches the timer count into capture buffer
// - capture bus select bit wins, feeding the bus clock to capture
// - comparator flag sets and sticks when positive input exceeds negative
// - writing one to flag clear clears the flag; it reads zero
// - interrupt request while flag set and interrupt enable set
// - clearing current source power at once stops source and discharge
module ssac_top #(
	parameter int CHANNELS = `SSAC_CHANNELS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic comp_out_i,
	input wire logic scl_i,
	input wire logic external_capture_pin_i,
	input wire logic timer_overflow_flag_i,
	input wire logic timer_compare_flag_i,
	input wire logic timer_capture_flag_i,
	input wire logic [15:0] timer_count_i,
	output logic comparator_power_o,
	output logic current_source_power_o,
	output logic ramp_pin_source_o,
	output logic ramp_pin_sink_o,
	output logic [CHANNELS-1:0] chan_en_o,
	output logic supply_en_o,
	output logic bias_en_o,
	output logic timer_capture_o,
	output logic irq_o
);
	import ssac_pkg::*;

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	ssac_mode_t mode_q, mode_d;
	logic chg_q, chg_d;
	logic current_source_power_q, current_source_power_d;
	logic comparator_power_q, comparator_irq_enable_q;
	logic capture_source_select_q, capture_source_select_d;
	logic flag_q, flag_d;
	logic capture_bus_select_q;
	logic supply_q, bias_q;
	ssac_byte_t chan_sw_q;
	logic [15:0] cap_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic src_q, sink_q, irq_q;
	logic req, wr, wr_acr, flag_clr, flag_set, flag_rise;
	logic [7:0] idx;

	ssac_ctl_if bus ();

	// ------------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------------
	assign idx = wb_adr_i[9:2];
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign wr_acr = wr & (idx == `SSAC_IDX_ACR);
	assign flag_clr = wr & (idx == `SSAC_IDX_STAT) & wb_dat_i[`SSAC_STAT_CLR];
	assign flag_set = comparator_power_q & bus.comp_s;
	assign flag_rise = flag_set & ~flag_q;

	// read mux, unmapped indices read zero
	function automatic ssac_byte_t rd_byte(input logic [7:0] i);
		ssac_byte_t b;
		b = `SSAC_RST_BYTE;
		if (i == `SSAC_IDX_ACR) begin
			b[`SSAC_ACR_CHG] = chg_q;
			b[`SSAC_ACR_MODE_HI] = mode_q[1];
			b[`SSAC_ACR_MODE_LO] = mode_q[0];
			b[`SSAC_ACR_CAPTURE_SOURCE_SELECT] = capture_source_select_q;
			b[`SSAC_ACR_COMPARATOR_IRQ_ENABLE] = comparator_irq_enable_q;
			b[`SSAC_ACR_COMPARATOR_POWER] = comparator_power_q;
			b[`SSAC_ACR_CURRENT_SOURCE_POWER] = current_source_power_q;
		end else if (i == `SSAC_IDX_STAT) begin
			b[`SSAC_STAT_FLAG] = flag_q;
		end else if (i == `SSAC_IDX_CHAN_A) begin
			b = chan_sw_q;
		end else if (i == `SSAC_IDX_CHAN_B) begin
			b[`SSAC_CHB_SUPPLY] = supply_q;
			b[`SSAC_CHB_BIAS] = bias_q;
		end else if (i == `SSAC_IDX_MISC) begin
			b[`SSAC_MISC_CAPTURE_BUS_SELECT] = capture_bus_select_q;
		end else if (i == `SSAC_IDX_CAP_HI) begin
			b = cap_q[15:8];
		end else if (i == `SSAC_IDX_CAP_LO) begin
			b = cap_q[7:0];
		end
		return b;
	endfunction : rd_byte

	// one wait cycle, ack for any address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req & ~wb_we_i) begin
				dat_q <= {24'h000000, rd_byte(idx)};
			end
		end
	end

	// ------------------------------------------------------------------------
	// analog control next values
	// ------------------------------------------------------------------------
	always_comb begin
		current_source_power_d = wr_acr ? wb_dat_i[`SSAC_ACR_CURRENT_SOURCE_POWER] : current_source_power_q;
		mode_d = wr_acr ? ssac_mode_t'(wb_dat_i[`SSAC_ACR_MODE_HI:`SSAC_ACR_MODE_LO]) : mode_q;
		capture_source_select_d = (wr_acr ? wb_dat_i[`SSAC_ACR_CAPTURE_SOURCE_SELECT] : capture_source_select_q) | mode_d[1];
	end

	// charge bit per conversion mode, mode bits inert unpowered
	always_comb begin
		chg_d = chg_q;
		case (mode_q)
			SSAC_MODE_MANUAL: begin
				if (wr_acr) begin
					chg_d = wb_dat_i[`SSAC_ACR_CHG];
				end
			end
			SSAC_MODE_AUTO_DIS: begin
				if (wr_acr) begin
					chg_d = wb_dat_i[`SSAC_ACR_CHG];
				end
				if (flag_rise) begin
					chg_d = 1'b0;
				end
			end
			SSAC_MODE_OVF_CAP: begin
				if (!chg_q && timer_overflow_flag_i) begin
					chg_d = 1'b1;
				end else if (chg_q && timer_capture_flag_i) begin
					chg_d = 1'b0;
				end
			end
			SSAC_MODE_CMP_CAP: begin
				if (!chg_q && timer_compare_flag_i) begin
					chg_d = 1'b1;
				end else if (chg_q && timer_capture_flag_i) begin
					chg_d = 1'b0;
				end
			end
			default: chg_d = chg_q;
		endcase
		if (!current_source_power_d) begin
			chg_d = 1'b0;
		end
	end

	// analog control register, all clear at reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			current_source_power_q <= 1'b0;
			comparator_power_q <= 1'b0;
			comparator_irq_enable_q <= 1'b0;
			mode_q <= SSAC_MODE_MANUAL;
			capture_source_select_q <= 1'b0;
			chg_q <= 1'b0;
		end else begin
			current_source_power_q <= current_source_power_d;
			mode_q <= mode_d;
			capture_source_select_q <= capture_source_select_d;
			chg_q <= chg_d;
			if (wr_acr) begin
				comparator_power_q <= wb_dat_i[`SSAC_ACR_COMPARATOR_POWER];
				comparator_irq_enable_q <= wb_dat_i[`SSAC_ACR_COMPARATOR_IRQ_ENABLE];
			end
		end
	end

	// ------------------------------------------------------------------------
	// channel, misc and flag registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chan_sw_q <= `SSAC_RST_BYTE;
			supply_q <= 1'b0;
			bias_q <= 1'b0;
			capture_bus_select_q <= 1'b0;
		end else begin
			if (wr && idx == `SSAC_IDX_CHAN_A) begin
				chan_sw_q <= wb_dat_i[7:0];
			end
			if (wr && idx == `SSAC_IDX_CHAN_B) begin
				supply_q <= wb_dat_i[`SSAC_CHB_SUPPLY];
				bias_q <= wb_dat_i[`SSAC_CHB_BIAS];
			end
			if (wr && idx == `SSAC_IDX_MISC) begin
				capture_bus_select_q <= wb_dat_i[`SSAC_MISC_CAPTURE_BUS_SELECT];
			end
		end
	end

	// sticky flag, a set in the clear cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else if (flag_set) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end
	assign flag_d = flag_set | (flag_q & ~flag_clr);

	// capture buffer loads on a comparator triggered capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_q <= `SSAC_RST_WORD;
		end else if (flag_rise && capture_source_select_q && !capture_bus_select_q) begin
			cap_q <= timer_count_i;
		end
	end

	// ------------------------------------------------------------------------
	// ramp pin drive and interrupt, registered outputs
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_q <= 1'b0;
			sink_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			src_q <= current_source_power_d & chg_d;
			sink_q <= current_source_power_d & ~chg_d;
			irq_q <= comparator_irq_enable_q & flag_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign comparator_power_o = comparator_power_q;
	assign current_source_power_o = current_source_power_q;
	assign ramp_pin_source_o = src_q;
	assign ramp_pin_sink_o = sink_q;
	assign irq_o = irq_q;

	// ------------------------------------------------------------------------
	// carrier and submodules
	// ------------------------------------------------------------------------
	assign bus.chan_sw = chan_sw_q;
	assign bus.supply_sel = supply_q;
	assign bus.bias_sel = bias_q;
	assign bus.capture_source_select = capture_source_select_q;
	assign bus.capture_bus_select = capture_bus_select_q;
	assign bus.flag = flag_q;

	ssac_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.comp_raw_i(comp_out_i),
		.scl_raw_i(scl_i),
		.ext_raw_i(external_capture_pin_i),
		.bus(bus.sync)
	);

	ssac_route #(.CHANNELS(CHANNELS)) u_route (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bus(bus.route),
		.chan_en_o(chan_en_o),
		.supply_en_o(supply_en_o),
		.bias_en_o(bias_en_o),
		.capture_o(timer_capture_o)
	);

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	chk_unpowered_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!current_source_power_q |-> !ramp_pin_source_o && !ramp_pin_sink_o && !chg_q)
		else $error("ramp pin driven while current source off");

	chk_drive_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
		current_source_power_q |-> ramp_pin_source_o == chg_q && ramp_pin_sink_o == !chg_q)
		else $error("ramp drive does not match charge bit");

	chk_mode1_end: assert property (@(posedge clk_i) disable iff (rst_i)
		current_source_power_q && mode_q == SSAC_MODE_AUTO_DIS && flag_rise |=> !chg_q)
		else $error("charge not ended by comparator flag");

	chk_ovf_start: assert property (@(posedge clk_i) disable iff (rst_i)
		current_source_power_q && !wr_acr && mode_q == SSAC_MODE_OVF_CAP && !chg_q && timer_overflow_flag_i
		|=> chg_q && ramp_pin_source_o)
		else $error("overflow did not start charge");

	chk_cmp_start: assert property (@(posedge clk_i) disable iff (rst_i)
		current_source_power_q && !wr_acr && mode_q == SSAC_MODE_CMP_CAP && !chg_q && timer_compare_flag_i
		|=> chg_q)
		else $error("compare did not start charge");

	chk_cap_end: assert property (@(posedge clk_i) disable iff (rst_i)
		current_source_power_q && !wr_acr && mode_q[1] && chg_q && timer_capture_flag_i |=> !chg_q)
		else $error("capture did not end charge");

	chk_capture_source_select_forced: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_q[1] |-> capture_source_select_q)
		else $error("capture source select not forced");

	chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		flag_q && !flag_clr |=> flag_q)
		else $error("comparator flag dropped without clear");

	chk_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		flag_clr && !flag_set |=> !flag_q && !irq_o)
		else $error("flag clear had no effect");

	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o |-> $past(comparator_irq_enable_q) && $past(flag_d))
		else $error("interrupt without enabled flag");

	chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule : ssac_top

// ---- ssac_map.svh ----
// register indices, field positions and reset values of the ramp converter control
`ifndef SSAC_MAP_SVH
`define SSAC_MAP_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SSAC_IDX_MISC 8'h0B
`define SSAC_IDX_CAP_HI 8'h14
`define SSAC_IDX_CAP_LO 8'h15
`define SSAC_IDX_ACR 8'h1D
`define SSAC_IDX_STAT 8'h1E
`define SSAC_IDX_CHAN_A 8'h1F
`define SSAC_IDX_CHAN_B 8'h20

// ----------------------------------------------------------------------------
// analog_control fields
// ----------------------------------------------------------------------------
`define SSAC_ACR_CHG 7
`define SSAC_ACR_MODE_HI 6
`define SSAC_ACR_MODE_LO 5
`define SSAC_ACR_CAPTURE_SOURCE_SELECT 4
`define SSAC_ACR_COMPARATOR_IRQ_ENABLE 3
`define SSAC_ACR_COMPARATOR_POWER 2
`define SSAC_ACR_CURRENT_SOURCE_POWER 1

// ----------------------------------------------------------------------------
// status, channel and misc fields
// ----------------------------------------------------------------------------
`define SSAC_STAT_FLAG 7
`define SSAC_STAT_CLR 6
`define SSAC_CHB_SUPPLY 1
`define SSAC_CHB_BIAS 0
`define SSAC_MISC_CAPTURE_BUS_SELECT 2

// ----------------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------------
`define SSAC_RST_BYTE 8'h00
`define SSAC_RST_WORD 16'h0000
`define SSAC_CHANNELS 8
`define SSAC_SYNC_STAGES 2

`endif

// ---- ssac_pkg.sv ----
// types shared by the ramp converter control modules
package ssac_pkg;

	// ------------------------------------------------------------------------
	// conversion modes
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		SSAC_MODE_MANUAL = 2'b00,
		SSAC_MODE_AUTO_DIS = 2'b01,
		SSAC_MODE_OVF_CAP = 2'b10,
		SSAC_MODE_CMP_CAP = 2'b11
	} ssac_mode_t;

	typedef logic [7:0] ssac_byte_t;

endpackage : ssac_pkg

// ---- ssac_ctl_if.sv ----
// carrier between the control core, the synchroniser and the routing stage
`timescale 1ns/1ns
interface ssac_ctl_if;
	logic [7:0] chan_sw;
	logic supply_sel;
	logic bias_sel;
	logic capture_source_select;
	logic capture_bus_select;
	logic flag;
	logic comp_s;
	logic scl_s;
	logic ext_s;

	modport ctl (
		output chan_sw, supply_sel, bias_sel, capture_source_select, capture_bus_select, flag,
		input comp_s, scl_s, ext_s
	);
	modport sync (
		output comp_s, scl_s, ext_s
	);
	modport route (
		input chan_sw, supply_sel, bias_sel, capture_source_select, capture_bus_select, flag, scl_s, ext_s
	);
endinterface : ssac_ctl_if

// ---- ssac_sync.sv ----
// two-flop synchronisers for the asynchronous inputs
`timescale 1ns/1ns
`include "ssac_map.svh"
module ssac_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic comp_raw_i,
	input wire logic scl_raw_i,
	input wire logic ext_raw_i,
	ssac_ctl_if.sync bus
);
	import ssac_pkg::*;

	logic [2:0] meta_q;
	logic [2:0] sync_q;

	// ------------------------------------------------------------------------
	// first stage feeds only the second
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
		end else begin
			meta_q <= {ext_raw_i, scl_raw_i, comp_raw_i};
			sync_q <= meta_q;
		end
	end

	assign bus.comp_s = sync_q[0];
	assign bus.scl_s = sync_q[1];
	assign bus.ext_s = sync_q[2];

	chk_comp_two_flop: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) == 1'b0 && $past(rst_i, 2) == 1'b0 |-> sync_q[0] == $past(comp_raw_i, 2))
		else $error("comparator sync is not two stages");

endmodule : ssac_sync

// ---- ssac_route.sv ----
// registered channel bus switches and timer capture source selection
`timescale 1ns/1ns
`include "ssac_map.svh"
module ssac_route #(
	parameter int CHANNELS = `SSAC_CHANNELS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	ssac_ctl_if.route bus,
	output logic [CHANNELS-1:0] chan_en_o,
	output logic supply_en_o,
	output logic bias_en_o,
	output logic capture_o
);
	import ssac_pkg::*;

	logic none_sel;

	assign none_sel = (bus.chan_sw == 8'h00);

	// ------------------------------------------------------------------------
	// per channel switch, any number closed at once
	// ------------------------------------------------------------------------
	for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				chan_en_o[g] <= 1'b0;
			end else begin
				chan_en_o[g] <= bus.chan_sw[g];
			end
		end
	end

	// references only when every channel switch is open
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			supply_en_o <= 1'b0;
			bias_en_o <= 1'b0;
		end else begin
			supply_en_o <= none_sel & bus.supply_sel;
			bias_en_o <= none_sel & bus.bias_sel;
		end
	end

	// capture source: bus clock first, then comparator flag, else pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			capture_o <= 1'b0;
		end else if (bus.capture_bus_select) begin
			capture_o <= bus.scl_s;
		end else if (bus.capture_source_select) begin
			capture_o <= bus.flag;
		end else begin
			capture_o <= bus.ext_s;
		end
	end

	chk_bus_clk_prio: assert property (@(posedge clk_i) disable iff (rst_i)
		bus.capture_bus_select |=> capture_o == $past(bus.scl_s))
		else $error("bus clock does not win capture source");

	chk_ref_open: assert property (@(posedge clk_i) disable iff (rst_i)
		bus.chan_sw != 8'h00 |=> !supply_en_o && !bias_en_o)
		else $error("reference closed with a channel selected");

endmodule : ssac_route

// ---- ssac_ramp_model.sv ----
// behavioural model of the comparator, ramp capacitor and 16-bit timer
`timescale 1ns/1ns
module ssac_ramp_model #(
	parameter int TOP = 63,
	parameter int CMP = 20,
	parameter int THR = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic source_i,
	input wire logic sink_i,
	input wire logic comparator_power_i,
	input wire logic capture_i,
	output logic comp_o,
	output logic [15:0] count_o,
	output logic ovf_o,
	output logic cmp_o,
	output logic icf_o
);
	logic [7:0] lvl_q;
	logic cap_q;

	// ------------------------------------------------------------------------
	// timer
	// ------------------------------------------------------------------------
	// short wrapping count keeps overflow events frequent
	always_ff @(posedge clk_i) begin
		if (rst_i || count_o == 16'(TOP)) count_o <= 16'h0000;
		else count_o <= count_o + 16'h0001;
	end
	assign ovf_o = (count_o == 16'(TOP));
	assign cmp_o = (count_o == 16'(CMP));
	// capture flag pulses one edge after the routed capture line rises
	always_ff @(posedge clk_i) begin
		cap_q <= !rst_i && capture_i;
		icf_o <= !rst_i && capture_i && !cap_q;
	end

	// ------------------------------------------------------------------------
	// ramp capacitor and comparator
	// ------------------------------------------------------------------------
	// voltage climbs while sourced, collapses while sunk, holds when floating
	always_ff @(posedge clk_i) begin
		if (rst_i || sink_i) lvl_q <= 8'h00;
		else if (source_i && lvl_q != 8'hFF) lvl_q <= lvl_q + 8'h01;
	end
	assign comp_o = comparator_power_i && (lvl_q >= 8'(THR)); // powered-down comparator reads low
endmodule : ssac_ramp_model

// ---- ssac_top_test.sv ----
// self-checking testbench of the ramp converter control
`timescale 1ns/1ns
`include "ssac_map.svh"
module ssac_top_test;
	localparam int TOP = 63;
	localparam int CMP = 20;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rnd;
	logic [3:0] wb_sel_i;
	logic wb_ack_o, comp, scl_i, ext_i, ovf, cmpf, timer_capture_flag, comparator_power, current_source_power, src, snk, cap_o, irq_o;
	logic [15:0] count, cap_exp;
	logic [7:0] chan_en_o;
	logic supply_en_o, bias_en_o;
	logic [31:0] exp_q[$];
	int n_mismatch, n_checks, i;

	ssac_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_out_i(comp), .scl_i(scl_i),
		.external_capture_pin_i(ext_i), .timer_overflow_flag_i(ovf),
		.timer_compare_flag_i(cmpf), .timer_capture_flag_i(timer_capture_flag), .timer_count_i(count),
		.comparator_power_o(comparator_power), .current_source_power_o(current_source_power), .ramp_pin_source_o(src),
		.ramp_pin_sink_o(snk), .chan_en_o(chan_en_o), .supply_en_o(supply_en_o),
		.bias_en_o(bias_en_o), .timer_capture_o(cap_o), .irq_o(irq_o));
	ssac_ramp_model #(.TOP(TOP), .CMP(CMP), .THR(12)) model_u (.clk_i(clk_i), .rst_i(rst_i),
		.source_i(src), .sink_i(snk), .comparator_power_i(comparator_power), .capture_i(cap_o), .comp_o(comp),
		.count_o(count), .ovf_o(ovf), .cmp_o(cmpf), .icf_o(timer_capture_flag));

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	function automatic void step();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
	endfunction : step
	// one classic cycle: hold everything until ack is sampled, then release
	task automatic wb_cycle(input logic [7:0] idx, input logic we, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {22'h0, idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 50) n_mismatch++; // a missing ack counts as a mismatch
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_cycle
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb_cycle(idx, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		exp_q.push_back({24'h0, exp});
		wb_cycle(idx, 1'b0, 8'h00);
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask : settle
	task automatic print_verdict();
		n_mismatch += exp_q.size(); // reads never answered
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------------------
	// clock, read monitor and watchdog
	// ------------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// oldest noted read value is compared when a read is acknowledged
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i && exp_q.size() > 0) begin
			check("wb_dat_o", wb_dat_o, exp_q.pop_front());
		end
	end
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end

	// ------------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------------
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, scl_i, ext_i} = 6'b100000;
		wb_adr_i = 32'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hF;
		rnd = 32'h7288;
		n_mismatch = 0;
		n_checks = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		check("ramp outputs", {comparator_power, current_source_power, src, snk, irq_o}, 32'h0);
		rd(`SSAC_IDX_ACR, 8'h00);
		rd(`SSAC_IDX_STAT, 8'h00);
		rd(8'h30, 8'h00);
		$display("test reset finished");
		// channel switches with both references requested
		wr(`SSAC_IDX_CHAN_B, 8'h03);
		for (i = 0; i < 4; i++) begin
			step();
			wr(`SSAC_IDX_CHAN_A, rnd[7:0]);
			settle(2);
			check("chan_en_o", 32'(chan_en_o), 32'(rnd[7:0]));
			check("refs", {supply_en_o, bias_en_o}, {2{rnd[7:0] == 8'h00}});
		end
		wr(`SSAC_IDX_CHAN_A, 8'h00);
		for (i = 1; i < 4; i++) begin
			wr(`SSAC_IDX_CHAN_B, 8'(i));
			settle(2);
			check("refs", {supply_en_o, bias_en_o}, 32'(i));
		end
		$display("test channels finished");
		// manual charge, power gating and unpowered modes
		wr(`SSAC_IDX_ACR, 8'h82);
		settle(30);
		check("source", {current_source_power, src, snk}, 32'h6);
		rd(`SSAC_IDX_ACR, 8'h82);
		wr(`SSAC_IDX_ACR, 8'h02);
		settle(2);
		check("sink", {src, snk}, 32'h1);
		wr(`SSAC_IDX_ACR, 8'h82);
		wr(`SSAC_IDX_ACR, 8'h80);
		settle(0);
		check("unpowered", {current_source_power, src, snk}, 32'h0);
		rd(`SSAC_IDX_ACR, 8'h00);
		wr(`SSAC_IDX_ACR, 8'hE4);
		settle(2);
		check("modes unpowered", {comparator_power, current_source_power, src, snk}, 32'h8);
		rd(`SSAC_IDX_ACR, 8'h74);
		$display("test power finished");
		// mode 1: comparator trip ends the charge
		wr(`SSAC_IDX_ACR, 8'h06);
		wr(`SSAC_IDX_STAT, 8'h40);
		wr(`SSAC_IDX_ACR, 8'hAE);
		for (i = 0; i < 100 && snk !== 1'b1; i++) @(negedge clk_i);
		settle(1);
		check("mode1 sink", {src, snk, irq_o}, 32'h3);
		rd(`SSAC_IDX_ACR, 8'h2E);
		rd(`SSAC_IDX_STAT, 8'h80);
		wr(`SSAC_IDX_STAT, 8'h40);
		rd(`SSAC_IDX_STAT, 8'h00);
		settle(1);
		check("irq_o", 32'(irq_o), 32'h0);
		$display("test mode1 finished");
		// mode 2: overflow starts, comparator captures, capture flag ends
		// write early in the timer period so no overflow lands before the read back
		for (i = 0; i < 100 && count !== 16'h0010; i++) @(negedge clk_i);
		wr(`SSAC_IDX_ACR, 8'h4E);
		rd(`SSAC_IDX_ACR, 8'h5E);
		for (i = 0; i < 200 && src !== 1'b1; i++) @(negedge clk_i);
		check("start count", 32'(count), 32'h0);
		for (i = 0; i < 200 && irq_o !== 1'b1; i++) @(negedge clk_i);
		cap_exp = (count - 16'h0001) & 16'(TOP);
		settle(1);
		check("capture line", 32'(cap_o), 32'h1);
		for (i = 0; i < 100 && snk !== 1'b1; i++) @(negedge clk_i);
		check("mode2 sink", {src, snk}, 32'h1);
		rd(`SSAC_IDX_CAP_HI, cap_exp[15:8]);
		rd(`SSAC_IDX_CAP_LO, cap_exp[7:0]);
		$display("test mode2 finished");
		// mode 3: compare event starts the charge
		// first write leaves mode 2, second ends the charge in manual mode
		wr(`SSAC_IDX_ACR, 8'h06);
		wr(`SSAC_IDX_ACR, 8'h06);
		settle(4);
		wr(`SSAC_IDX_STAT, 8'h40);
		rd(`SSAC_IDX_STAT, 8'h00);
		wr(`SSAC_IDX_ACR, 8'h6E);
		for (i = 0; i < 200 && src !== 1'b1; i++) @(negedge clk_i);
		check("start count", 32'(count), 32'(CMP + 1));
		wr(`SSAC_IDX_ACR, 8'h00);
		settle(0);
		check("off", {src, snk}, 32'h0);
		$display("test mode3 finished");
		// capture routing: bus clock line wins, then external pin
		wr(`SSAC_IDX_MISC, 8'h04);
		for (i = 0; i < 8; i++) begin
			if (i == 4) wr(`SSAC_IDX_MISC, 8'h00);
			step();
			@(posedge clk_i);
			scl_i <= rnd[0];
			ext_i <= rnd[1];
			settle(5);
			check("timer_capture_o", 32'(cap_o), 32'(i < 4 ? rnd[0] : rnd[1]));
		end
		$display("test routing finished");
		print_verdict();
	end
endmodule : ssac_top_test
